// ---- hw/rbt_pkg.sv ----
package rbt_pkg;
   localparam int DATA_W = 8;
   localparam int LOG_DEPTH = 8;
   localparam int AXI_AW = 8;
   localparam int CTRL_W = 4;

   localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] ADDR_AREG = 8'h04;
   localparam logic [AXI_AW-1:0] ADDR_BREG = 8'h08;
   localparam logic [AXI_AW-1:0] ADDR_LIVE = 8'h0c;
   localparam logic [AXI_AW-1:0] ADDR_LOG = 8'h10;
   localparam logic [AXI_AW-1:0] ADDR_STAT = 8'h14;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int LOG_VALID_BIT = 31;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_EMPTY_BIT = 1;

   typedef struct packed {
      logic b_output_source_select;
      logic a_output_source_select;
      logic flow_toward_b;
      logic bus_drive_enable_n;
   } rbt_ctrl_t;

   localparam rbt_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b1};

   typedef struct packed {
      logic got_b;
      logic got_a;
      logic [DATA_W-1:0] b_data;
      logic [DATA_W-1:0] a_data;
   } rbt_log_t;

   localparam int LOG_W = $bits(rbt_log_t);
endpackage

// ---- hw/rbt_top.sv ----
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps

module rbt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;

   assign out_valid = (wr_q != rd_q);
   assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
   assign out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge aclk) begin
      if (in_valid && in_ready) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= '0;
      end else if (in_valid && in_ready) begin
         wr_q <= wr_q + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_q <= '0;
      end else if (out_valid && out_ready) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule

module rbt_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic a_to_b_capture_clock,
   input wire logic b_to_a_capture_clock,
   input wire logic [rbt_pkg::DATA_W-1:0] port_a_lines_sense,
   output logic [rbt_pkg::DATA_W-1:0] port_a_lines_drive,
   output logic port_a_lines_oe_n,
   input wire logic [rbt_pkg::DATA_W-1:0] port_b_lines_sense,
   output logic [rbt_pkg::DATA_W-1:0] port_b_lines_drive,
   output logic port_b_lines_oe_n,
   output logic capture_log_ready,
   input wire logic [rbt_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rbt_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int W = rbt_pkg::DATA_W;

   function automatic logic addr_mapped(input logic [rbt_pkg::AXI_AW-1:0] addr);
      return addr inside {rbt_pkg::ADDR_CTRL, rbt_pkg::ADDR_AREG, rbt_pkg::ADDR_BREG,
                          rbt_pkg::ADDR_LIVE, rbt_pkg::ADDR_LOG, rbt_pkg::ADDR_STAT};
   endfunction

   function automatic logic [W-1:0] pick_source(input logic stored_sel,
                                                input logic [W-1:0] live,
                                                input logic [W-1:0] stored);
      return stored_sel ? stored : live;
   endfunction

   rbt_pkg::rbt_ctrl_t ctrl_q;
   logic [2:0] clk_ab_sync_q;
   logic [2:0] clk_ba_sync_q;
   logic [W-1:0] a_meta_q;
   logic [W-1:0] a_live_q;
   logic [W-1:0] b_meta_q;
   logic [W-1:0] b_live_q;
   logic [W-1:0] a_reg_q;
   logic [W-1:0] b_reg_q;
   logic edge_ab;
   logic edge_ba;
   logic drive_a_d;
   logic drive_b_d;
   logic ovf_q;
   rbt_pkg::rbt_log_t log_in;
   rbt_pkg::rbt_log_t log_out;
   logic log_push;
   logic log_out_valid;
   logic log_pop;
   logic wr_go;
   logic rd_go;

   // Pins are asynchronous; data and clock take equal sync depth so they stay aligned
   always_ff @(posedge aclk) begin
      a_meta_q <= port_a_lines_sense;
      a_live_q <= a_meta_q;
      b_meta_q <= port_b_lines_sense;
      b_live_q <= b_meta_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_ab_sync_q <= '0;
         clk_ba_sync_q <= '0;
      end else begin
         clk_ab_sync_q <= {clk_ab_sync_q[1:0], a_to_b_capture_clock};
         clk_ba_sync_q <= {clk_ba_sync_q[1:0], b_to_a_capture_clock};
      end
   end

   assign edge_ab = clk_ab_sync_q[1] && !clk_ab_sync_q[2];
   assign edge_ba = clk_ba_sync_q[1] && !clk_ba_sync_q[2];

   // capture on edges; no gating by enable or direction
   // no reset on the stored bytes; all eight bits as one vector
   always_ff @(posedge aclk) begin
      if (edge_ab) begin
         a_reg_q <= a_live_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (edge_ba) begin
         b_reg_q <= b_live_q;
      end
   end

   // enables come from control bits only
   assign drive_a_d = !ctrl_q.bus_drive_enable_n && !ctrl_q.flow_toward_b;
   assign drive_b_d = !ctrl_q.bus_drive_enable_n && ctrl_q.flow_toward_b;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_a_lines_oe_n <= 1'b1;
         port_b_lines_oe_n <= 1'b1;
      end else begin
         port_a_lines_oe_n <= !drive_a_d;
         port_b_lines_oe_n <= !drive_b_d;
      end
   end

   // live or stored source per port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_a_lines_drive <= '0;
         port_b_lines_drive <= '0;
      end else begin
         port_a_lines_drive <= pick_source(ctrl_q.a_output_source_select, b_live_q, b_reg_q);
         port_b_lines_drive <= pick_source(ctrl_q.b_output_source_select, a_live_q, a_reg_q);
      end
   end

   // Capture log; captures never stall, so a full log drops and flags overflow
   assign log_in = '{got_b: edge_ba, got_a: edge_ab, b_data: b_live_q, a_data: a_live_q};
   assign log_push = edge_ab || edge_ba;

   rbt_fifo #(.WIDTH(rbt_pkg::LOG_W), .DEPTH(rbt_pkg::LOG_DEPTH)) u_log (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(log_push),
      .in_ready(capture_log_ready),
      .in_data(log_in),
      .out_valid(log_out_valid),
      .out_ready(log_pop),
      .out_data(log_out)
   );

   // AXI4-Lite write: both channels taken together once no response is pending
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= rbt_pkg::CTRL_RESET;
      end else if (wr_go && s_axi_awaddr == rbt_pkg::ADDR_CTRL && s_axi_wstrb[0]) begin
         ctrl_q <= rbt_pkg::rbt_ctrl_t'(s_axi_wdata[rbt_pkg::CTRL_W-1:0]);
      end
   end

   // Overflow sticky: a new drop in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_q <= 1'b0;
      end else if (log_push && !capture_log_ready) begin
         ovf_q <= 1'b1;
      end else if (wr_go && s_axi_awaddr == rbt_pkg::ADDR_STAT && s_axi_wstrb[0]
                   && s_axi_wdata[rbt_pkg::STAT_OVF_BIT]) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rbt_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_mapped(s_axi_awaddr) ? rbt_pkg::RESP_OKAY : rbt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read; reading the log pops one entry
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign log_pop = rd_go && s_axi_araddr == rbt_pkg::ADDR_LOG;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= rbt_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_mapped(s_axi_araddr) ? rbt_pkg::RESP_OKAY : rbt_pkg::RESP_SLVERR;
         s_axi_rdata <= '0;
         case (s_axi_araddr)
            rbt_pkg::ADDR_CTRL: s_axi_rdata[rbt_pkg::CTRL_W-1:0] <= ctrl_q;
            rbt_pkg::ADDR_AREG: s_axi_rdata[W-1:0] <= a_reg_q;
            rbt_pkg::ADDR_BREG: s_axi_rdata[W-1:0] <= b_reg_q;
            rbt_pkg::ADDR_LIVE: s_axi_rdata[2*W-1:0] <= {b_live_q, a_live_q};
            rbt_pkg::ADDR_LOG: begin
               if (log_out_valid) begin
                  s_axi_rdata[rbt_pkg::LOG_W-1:0] <= log_out;
                  s_axi_rdata[rbt_pkg::LOG_VALID_BIT] <= 1'b1;
               end
            end
            rbt_pkg::ADDR_STAT: begin
               s_axi_rdata[rbt_pkg::STAT_OVF_BIT] <= ovf_q;
               s_axi_rdata[rbt_pkg::STAT_EMPTY_BIT] <= !log_out_valid;
            end
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_a_capture: assert property (edge_ab |=> a_reg_q == $past(a_live_q))
      else $error("A register missed capture");
   chk_b_capture: assert property (edge_ba |=> b_reg_q == $past(b_live_q))
      else $error("B register missed capture");
   chk_reg_hold: assert property (!edge_ab && !edge_ba |=>
         $stable(a_reg_q) && $stable(b_reg_q))
      else $error("Register changed without capture edge");
   chk_isolate_float: assert property (ctrl_q.bus_drive_enable_n |=>
         port_a_lines_oe_n && port_b_lines_oe_n)
      else $error("Port driven while disabled");
   chk_dir_select: assert property (!ctrl_q.bus_drive_enable_n |=>
         port_b_lines_oe_n == $past(!ctrl_q.flow_toward_b)
         && port_a_lines_oe_n == $past(ctrl_q.flow_toward_b))
      else $error("Wrong port driven for direction");
   chk_one_port: assert property (!(!port_a_lines_oe_n && !port_b_lines_oe_n))
      else $error("Both ports driven");
   chk_a_live_path: assert property (!ctrl_q.a_output_source_select |=>
         port_a_lines_drive == $past(b_live_q))
      else $error("Port A not showing live B");
   chk_a_stored_path: assert property (ctrl_q.a_output_source_select |=>
         port_a_lines_drive == $past(b_reg_q))
      else $error("Port A not showing B register");
   chk_b_live_path: assert property (!ctrl_q.b_output_source_select |=>
         port_b_lines_drive == $past(a_live_q))
      else $error("Port B not showing live A");
   chk_b_stored_path: assert property (ctrl_q.b_output_source_select |=>
         port_b_lines_drive == $past(a_reg_q))
      else $error("Port B not showing A register");
   chk_clock_no_oe: assert property ($stable(ctrl_q) ##1 $stable(ctrl_q) |->
         $stable(port_a_lines_oe_n) && $stable(port_b_lines_oe_n))
      else $error("Port enable moved without control change");

   cov_dual_capture: cover property (edge_ab && edge_ba && ctrl_q.bus_drive_enable_n);
   cov_capture_driving: cover property (edge_ab && !ctrl_q.bus_drive_enable_n
         && !ctrl_q.flow_toward_b);
   cov_log_full: cover property (log_push && !capture_log_ready);
   cov_stored_out: cover property (!port_b_lines_oe_n && ctrl_q.b_output_source_select);
endmodule

// ---- dv/rbt_bus_model.sv ----
`timescale 1ns/100ps

module rbt_bus_model (
   input wire logic [rbt_pkg::DATA_W-1:0] a_far,
   input wire logic [rbt_pkg::DATA_W-1:0] b_far,
   input wire logic a_oe_n,
   input wire logic [rbt_pkg::DATA_W-1:0] a_drive,
   input wire logic b_oe_n,
   input wire logic [rbt_pkg::DATA_W-1:0] b_drive,
   output logic [rbt_pkg::DATA_W-1:0] a_sense,
   output logic [rbt_pkg::DATA_W-1:0] b_sense
);
   // far side yields
   // Outside logic lets go of a bus whenever the block drives it
   assign a_sense = a_oe_n ? a_far : a_drive;
   assign b_sense = b_oe_n ? b_far : b_drive;
endmodule

// ---- dv/rbt_top_test.sv ----
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end

module rbt_top_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clk_ab = 1'b0;
   logic clk_ba = 1'b0;
   logic [7:0] a_far = 8'h00;
   logic [7:0] b_far = 8'h00;
   logic [7:0] a_sense, b_sense, a_drive, b_drive;
   logic a_oe_n, b_oe_n, log_ready;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   rbt_top u_dut (.aclk(aclk), .aresetn(aresetn), .a_to_b_capture_clock(clk_ab),
      .b_to_a_capture_clock(clk_ba), .port_a_lines_sense(a_sense), .port_a_lines_drive(a_drive),
      .port_a_lines_oe_n(a_oe_n), .port_b_lines_sense(b_sense), .port_b_lines_drive(b_drive),
      .port_b_lines_oe_n(b_oe_n), .capture_log_ready(log_ready), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   rbt_bus_model u_far (.a_far(a_far), .b_far(b_far), .a_oe_n(a_oe_n), .a_drive(a_drive),
      .b_oe_n(b_oe_n), .b_drive(b_drive), .a_sense(a_sense), .b_sense(b_sense));

   always #2 aclk = ~aclk;

   // Generous ceiling; the full run needs a few hundred cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Data held steady well around the edge so the synchroniser sees one value
   task automatic cap(input logic [7:0] av, input logic [7:0] bv, input logic da,
                      input logic db);
      a_far <= av;
      b_far <= bv;
      idle(3);
      clk_ab <= da;
      clk_ba <= db;
      idle(3);
      clk_ab <= 1'b0;
      clk_ba <= 1'b0;
      idle(4);
   endtask

   task automatic t_reset();
      `CHK("a_oe_n", 1'b1, a_oe_n)
      `CHK("b_oe_n", 1'b1, b_oe_n)
      rdr(rbt_pkg::ADDR_CTRL);
      `CHK("ctrl", 4'h1, rd[3:0])
      `CHK("rresp ok", rbt_pkg::RESP_OKAY, rs)
      $display("test reset done");
   endtask

   task automatic t_isolate();
      cap(8'h5a, 8'hc3, 1'b1, 1'b1);
      `CHK("oe_n pair", 2'b11, {a_oe_n, b_oe_n})
      rdr(rbt_pkg::ADDR_AREG);
      `CHK("areg", 8'h5a, rd[7:0])
      rdr(rbt_pkg::ADDR_BREG);
      `CHK("breg", 8'hc3, rd[7:0])
      rdr(rbt_pkg::ADDR_LIVE);
      `CHK("live", 16'hc35a, rd[15:0])
      a_far <= 8'h3c;
      b_far <= 8'h96;
      idle(8);
      rdr(rbt_pkg::ADDR_AREG);
      `CHK("areg hold", 8'h5a, rd[7:0])
      $display("test isolate done");
   endtask

   task automatic t_modes();
      logic [3:0] cv [4];
      logic [7:0] ev [4];
      cv = '{4'h0, 4'h4, 4'h2, 4'ha};
      ev = '{8'h96, 8'hc3, 8'h3c, 8'h5a};
      for (int i = 0; i < 4; i++) begin
         wr(rbt_pkg::ADDR_CTRL, {28'h0, cv[i]});
         idle(6);
         `CHK("oe_n pair", {cv[i][1], ~cv[i][1]}, {a_oe_n, b_oe_n})
         `CHK("drive", ev[i], cv[i][1] ? b_drive : a_drive)
      end
      $display("test modes done");
   endtask

   task automatic t_drive_cap();
      wr(rbt_pkg::ADDR_CTRL, 32'ha);
      cap(8'h81, 8'h00, 1'b1, 1'b0);
      `CHK("b_drive", 8'h81, b_drive)
      `CHK("b_oe_n", 1'b0, b_oe_n)
      wr(rbt_pkg::ADDR_CTRL, 32'h4);
      cap(8'h00, 8'h24, 1'b0, 1'b1);
      `CHK("a_drive", 8'h24, a_drive)
      wr(rbt_pkg::ADDR_CTRL, 32'h1);
      $display("test drive_cap done");
   endtask

   task automatic t_unmapped();
      rdr(8'h40);
      `CHK("rresp", rbt_pkg::RESP_SLVERR, rs)
      wr(8'h40, 32'h0);
      `CHK("bresp", rbt_pkg::RESP_SLVERR, rs)
      // Byte lane 0 off: the control byte must not move
      wstrb <= 4'h0;
      wr(rbt_pkg::ADDR_CTRL, 32'h2);
      wstrb <= 4'hf;
      idle(4);
      `CHK("oe_n pair", 2'b11, {a_oe_n, b_oe_n})
      rdr(rbt_pkg::ADDR_CTRL);
      `CHK("ctrl masked", 4'h1, rd[3:0])
      $display("test unmapped done");
   endtask

   task automatic t_log();
      for (int i = 0; i < 16; i++) rdr(rbt_pkg::ADDR_LOG);
      for (int i = 1; i < 10; i++) cap(8'(i), 8'h00, 1'b1, 1'b0);
      `CHK("log_ready", 1'b0, log_ready)
      rdr(rbt_pkg::ADDR_STAT);
      `CHK("overflow", 1'b1, rd[rbt_pkg::STAT_OVF_BIT])
      for (int i = 1; i < 9; i++) begin
         rdr(rbt_pkg::ADDR_LOG);
         `CHK("log", {3'b101, 8'(i)}, {rd[31], rd[17:16], rd[7:0]})
      end
      rdr(rbt_pkg::ADDR_LOG);
      `CHK("log empty", 1'b0, rd[31])
      wr(rbt_pkg::ADDR_STAT, 32'h1);
      rdr(rbt_pkg::ADDR_STAT);
      `CHK("stat", 2'b10, rd[1:0])
      `CHK("log_ready", 1'b1, log_ready)
      $display("test log done");
   endtask

   // Reset in mid-run while driving; stored bytes survive it
   task automatic t_midreset();
      wr(rbt_pkg::ADDR_CTRL, 32'h2);
      `CHK("bresp ok", rbt_pkg::RESP_OKAY, rs)
      idle(6);
      `CHK("b_oe_n", 1'b0, b_oe_n)
      aresetn <= 1'b0;
      idle(2);
      aresetn <= 1'b1;
      idle(4);
      `CHK("oe_n pair", 2'b11, {a_oe_n, b_oe_n})
      rdr(rbt_pkg::ADDR_AREG);
      `CHK("areg kept", 8'h09, rd[7:0])
      rdr(rbt_pkg::ADDR_BREG);
      `CHK("breg kept", 8'h24, rd[7:0])
      $display("test midreset done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      idle(6);
      aresetn <= 1'b1;
      idle(4);
      t_reset();
      t_isolate();
      t_modes();
      t_drive_cap();
      t_unmapped();
      t_log();
      t_midreset();
      test_done();
   end
endmodule
